// ===== hdl/ems_defs.svh
// Register offsets, field positions and reset values of the exception mode stack
`ifndef EMS_DEFS_SVH
`define EMS_DEFS_SVH

// Register byte offsets on the APB window
`define EMS_ADDR_MODE       12'h000
`define EMS_ADDR_SWINT      12'h004
`define EMS_ADDR_INT_STATUS 12'h008
`define EMS_ADDR_INT_MASK   12'h00c

// Mode register layout: {ku_old, ie_old, ku_prev, ie_prev, ku_cur, ie_cur}
`define EMS_IE_CUR      0
`define EMS_KU_CUR      1
`define EMS_IE_PREV     2
`define EMS_KU_PREV     3
`define EMS_STACK_MSB   5
`define EMS_CUR_MSB     1
`define EMS_PREV_LSB    2
`define EMS_PREV_MSB    3
`define EMS_OLD_LSB     4
`define EMS_IMASK_LSB   8
`define EMS_IMASK_MSB   15

// Field values
`define EMS_KERNEL      1'b0
`define EMS_IE_OFF      1'b0
`define EMS_STACK_RST   6'h00
`define EMS_IMASK_RST   8'h00
`define EMS_SWINT_MSB   1
`define EMS_SWINT_RST   2'h0

// Interrupt status event bits
`define EMS_EV_EXC      0
`define EMS_EV_RFE      1
`define EMS_EV_IRQ      2
`define EMS_EV_COND     3
`define EMS_EV_MSB      3
`define EMS_EV_RST      4'h0

`define EMS_ZERO32      32'h0000_0000

`endif

// ===== hdl/ems_pkg.sv
// Types shared by the exception mode stack modules
package ems_pkg;
    typedef logic [1:0] ems_pair_type;
    typedef enum logic
    {
        EMS_BR_FALSE = 1'b0,
        EMS_BR_TRUE  = 1'b1
    } ems_br_form_type;
endpackage

// ===== hdl/ems_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module ems_sync
    import ems_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // One chain per bit; first stage is read only by the second
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            logic meta_ff;
            logic sync_ff;
            always_ff @(posedge clock or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    meta_ff <= 1'b0;
                    sync_ff <= 1'b0;
                end
                else
                begin
                    meta_ff <= async_in[i];
                    sync_ff <= meta_ff;
                end
            end
            assign sync_out[i] = sync_ff;
        end
    endgenerate

endmodule

// ===== hdl/ems_branch_eval.sv
// Resolves coprocessor conditional branches against the condition inputs
`timescale 1ns/10ps
module ems_branch_eval
    import ems_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [1:0] cond_sync,
    input  wire logic       cop_cond_branch_true,
    input  wire logic       cop_cond_branch_false,
    input  wire logic       cond_select,
    output logic            cond_taken_ff,
    output logic            cond_valid_ff
);

    ems_br_form_type form;
    logic            sel_level;
    logic            nxt_cond_taken;

    // True form wins if a broken decode raises both
    assign form           = cop_cond_branch_true ? EMS_BR_TRUE : EMS_BR_FALSE;
    assign sel_level      = cond_select ? cond_sync[1] : cond_sync[0];
    assign nxt_cond_taken = (form == EMS_BR_TRUE) ? sel_level : !sel_level;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cond_taken_ff <= 1'b0;
            cond_valid_ff <= 1'b0;
        end
        else
        begin
            cond_valid_ff <= cop_cond_branch_true | cop_cond_branch_false;
            cond_taken_ff <= (cop_cond_branch_true | cop_cond_branch_false) & nxt_cond_taken;
        end
    end

endmodule

// ===== hdl/ems_top.sv
// Exception mode stack: enable/mode stack, interrupt gating, branch conditions, APB
`timescale 1ns/10ps
`include "ems_defs.svh"

module ems_top
    import ems_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [5:0]  ext_irq_in,
    input  wire logic [1:0]  branch_condition_inputs,
    input  wire logic        exc_take,
    input  wire logic        rfe_exec,
    input  wire logic        jump_reg_exec,
    input  wire logic        cop_cond_branch_true,
    input  wire logic        cop_cond_branch_false,
    input  wire logic        cond_select,
    output logic             irq_request,
    output logic             kernel_mode,
    output logic             global_irq_enable,
    output logic             kernel_user_flag,
    output logic             target_fetch,
    output logic             cond_taken,
    output logic             cond_valid,
    output logic             irq
);

    logic [1:0]              rst_n_ff;
    logic                    rst_n;
    logic [`EMS_STACK_MSB:0] stack_ff;
    logic [`EMS_STACK_MSB:0] nxt_stack;
    logic [7:0]              imask_ff;
    logic [`EMS_SWINT_MSB:0] swint_ff;
    logic [`EMS_EV_MSB:0]    status_ff;
    logic [`EMS_EV_MSB:0]    nxt_status;
    logic [`EMS_EV_MSB:0]    evmask_ff;
    logic [`EMS_EV_MSB:0]    events;
    logic [31:0]             prdata_ff;
    logic                    pready_ff;
    logic                    pslverr_ff;
    logic                    irq_request_ff;
    logic                    kernel_mode_ff;
    logic                    jump_pend_ff;
    logic                    target_fetch_ff;
    logic                    irq_ff;
    logic [1:0]              cond_prev_ff;
    logic [7:0]              pin_sync;
    logic [5:0]              ext_sync;
    logic [1:0]              cond_sync;
    logic [7:0]              pending;
    logic                    nxt_irq_request;
    logic                    setup;
    logic                    wr_en;
    logic                    hit_mode;
    logic                    hit_swint;
    logic                    hit_status;
    logic                    hit_mask;
    logic                    mapped;
    logic [31:0]             rd_data;
    logic                    do_push;
    logic                    do_pop;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            rst_n_ff <= 2'b00;
        else
            rst_n_ff <= {rst_n_ff[0], 1'b1};
    end
    assign rst_n = rst_n_ff[1];

    // Pin inputs: interrupt lines low, branch conditions (bits 6 and 7) high
    ems_sync #(
        .WIDTH    (8)
    ) ems_sync_i (
        .clock    (clock),
        .rst_n    (rst_n),
        .async_in ({branch_condition_inputs, ext_irq_in}),
        .sync_out (pin_sync)
    );
    assign ext_sync  = pin_sync[5:0];
    assign cond_sync = pin_sync[7:6];

    // Branch resolution against condition inputs
    ems_branch_eval ems_branch_eval_i (
        .clock                 (clock),
        .rst_n                 (rst_n),
        .cond_sync             (cond_sync),
        .cop_cond_branch_true  (cop_cond_branch_true),
        .cop_cond_branch_false (cop_cond_branch_false),
        .cond_select           (cond_select),
        .cond_taken_ff         (cond_taken),
        .cond_valid_ff         (cond_valid)
    );

    // APB decode; no wait state, pready and prdata registered in the setup cycle keep prdata a flop
    assign setup      = psel & ~penable & ~pready_ff;
    assign wr_en      = psel & penable & pready_ff & pwrite & ~pslverr_ff;
    assign hit_mode   = (paddr == `EMS_ADDR_MODE);
    assign hit_swint  = (paddr == `EMS_ADDR_SWINT);
    assign hit_status = (paddr == `EMS_ADDR_INT_STATUS);
    assign hit_mask   = (paddr == `EMS_ADDR_INT_MASK);
    assign mapped     = hit_mode | hit_swint | hit_status | hit_mask;

    // Read mux; unused bits read zero
    assign rd_data = hit_mode   ? {16'h0000, imask_ff, 2'b00, stack_ff} :
                     hit_swint  ? {30'h0000_0000, swint_ff} :
                     hit_status ? {28'h000_0000, status_ff} :
                     hit_mask   ? {28'h000_0000, evmask_ff} : `EMS_ZERO32;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= `EMS_ZERO32;
        end
        else
        begin
            pready_ff  <= setup;
            pslverr_ff <= setup & ~mapped;
            prdata_ff  <= (setup & ~pwrite) ? rd_data : `EMS_ZERO32;
        end
    end

    // Stack moves; exception wins over a same-cycle return
    assign do_push = exc_take;
    assign do_pop  = rfe_exec & ~exc_take;
    assign nxt_stack =
        do_push ? {stack_ff[`EMS_PREV_MSB:0], `EMS_KERNEL, `EMS_IE_OFF} :
        do_pop  ? {stack_ff[`EMS_STACK_MSB:`EMS_OLD_LSB],
                   stack_ff[`EMS_STACK_MSB:`EMS_PREV_LSB]} :
        (wr_en & hit_mode) ? pwdata[`EMS_STACK_MSB:0] : stack_ff;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            stack_ff <= `EMS_STACK_RST;
        else
            stack_ff <= nxt_stack;
    end

    // Mask and software interrupt registers
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            imask_ff <= `EMS_IMASK_RST;
            swint_ff <= `EMS_SWINT_RST;
        end
        else
        begin
            if (wr_en & hit_mode)
                imask_ff <= pwdata[`EMS_IMASK_MSB:`EMS_IMASK_LSB];
            if (wr_en & hit_swint)
                swint_ff <= pwdata[`EMS_SWINT_MSB:0];
        end
    end

    // Only these eight sources are gated; other exceptions bypass this
    assign pending         = {swint_ff, ext_sync};
    assign nxt_irq_request = (|(pending & imask_ff)) & stack_ff[`EMS_IE_CUR];

    // Delay slot: target fetch follows the slot, so a slot return lands first
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            jump_pend_ff    <= 1'b0;
            target_fetch_ff <= 1'b0;
        end
        else
        begin
            jump_pend_ff    <= jump_reg_exec;
            target_fetch_ff <= jump_pend_ff;
        end
    end

    // Mode outputs from flops; kernel_mode tracks the next stack value, irq_request the current enable
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_request_ff <= 1'b0;
            kernel_mode_ff <= 1'b1;
            cond_prev_ff   <= 2'b00;
        end
        else
        begin
            irq_request_ff <= nxt_irq_request;
            kernel_mode_ff <= (nxt_stack[`EMS_KU_CUR] == `EMS_KERNEL);
            cond_prev_ff   <= cond_sync;
        end
    end

    // Sticky events; a set in the clearing cycle wins
    assign events[`EMS_EV_EXC]  = exc_take;
    assign events[`EMS_EV_RFE]  = do_pop;
    assign events[`EMS_EV_IRQ]  = nxt_irq_request & ~irq_request_ff;
    assign events[`EMS_EV_COND] = |(cond_sync & ~cond_prev_ff);
    assign nxt_status = (status_ff & ~((wr_en & hit_status) ? pwdata[`EMS_EV_MSB:0]
                                                             : `EMS_EV_RST)) | events;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status_ff <= `EMS_EV_RST;
            evmask_ff <= `EMS_EV_RST;
            irq_ff    <= 1'b0;
        end
        else
        begin
            status_ff <= nxt_status;
            if (wr_en & hit_mask)
                evmask_ff <= pwdata[`EMS_EV_MSB:0];
            irq_ff    <= |(status_ff & evmask_ff);
        end
    end

    // Output wiring straight from flops
    assign prdata            = prdata_ff;
    assign pready            = pready_ff;
    assign pslverr           = pslverr_ff;
    assign irq_request       = irq_request_ff;
    assign kernel_mode       = kernel_mode_ff;
    assign global_irq_enable = stack_ff[`EMS_IE_CUR];
    assign kernel_user_flag  = stack_ff[`EMS_KU_CUR];
    assign target_fetch      = target_fetch_ff;
    assign irq               = irq_ff;

    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_jump_slot_rfe;
        jump_reg_exec ##1 (rfe_exec && !exc_take);
    endsequence

    sequence s_pop;
        rfe_exec && !exc_take;
    endsequence

    a_push_saves_prev: assert property (
        exc_take |=> stack_ff[`EMS_PREV_MSB:`EMS_PREV_LSB] == $past(stack_ff[`EMS_CUR_MSB:0]))
        else $error("exception did not save current pair");

    a_push_kernel_off: assert property (
        exc_take |=> (stack_ff[`EMS_CUR_MSB:0] == 2'b00) && kernel_mode_ff)
        else $error("exception did not force kernel with enable off");

    a_irq_needs_ie: assert property (
        irq_request_ff |-> $past(stack_ff[`EMS_IE_CUR]))
        else $error("interrupt raised while enable clear");

    a_irq_mask_gate: assert property (
        ((|(pending & imask_ff)) && stack_ff[`EMS_IE_CUR]) |=> irq_request_ff)
        else $error("enabled masked-in interrupt not raised");

    a_pop_moves_pairs: assert property (
        s_pop |=> (stack_ff[`EMS_CUR_MSB:0] == $past(stack_ff[`EMS_PREV_MSB:`EMS_PREV_LSB]))
              && (stack_ff[`EMS_PREV_MSB:`EMS_PREV_LSB]
                  == $past(stack_ff[`EMS_STACK_MSB:`EMS_OLD_LSB])))
        else $error("return did not pop the stack");

    a_pop_keeps_old: assert property (
        s_pop |=> $stable(stack_ff[`EMS_STACK_MSB:`EMS_OLD_LSB]))
        else $error("return changed the old pair");

    a_kernel_decode: assert property (
        kernel_mode_ff == (stack_ff[`EMS_KU_CUR] == `EMS_KERNEL))
        else $error("kernel output disagrees with mode flag");

    a_slot_rfe_first: assert property (
        s_jump_slot_rfe |=> target_fetch_ff
            && stack_ff[`EMS_CUR_MSB:0] == $past(stack_ff[`EMS_PREV_MSB:`EMS_PREV_LSB]))
        else $error("target fetched before slot return took effect");

    a_cond_sync_age: assert property (
        ##2 cond_sync == $past(branch_condition_inputs, 2))
        else $error("condition inputs not two flops deep");

    a_cond_branch: assert property (
        (cop_cond_branch_false && !cop_cond_branch_true) |=>
            cond_valid && cond_taken == !$past(cond_select ? cond_sync[1] : cond_sync[0]))
        else $error("false-form branch resolved wrongly");

endmodule

// ===== tb/ems_agent.sv
// Model of the external interrupt sources and branch condition agents
`timescale 1ns/10ps
module ems_agent
    import ems_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       fire,
    input  wire logic       clear,
    input  wire logic [2:0] line,
    input  wire logic       sel,
    output logic      [5:0] ext_irq_in,
    output logic      [1:0] branch_condition_inputs
);
    logic [5:0] irq_ff  = 6'h00;
    logic [1:0] cond_ff = 2'h0;

    // An event raises its condition and one interrupt line together
    always @(posedge clock)
    begin
        if (clear)
        begin
            irq_ff  <= 6'h00;
            cond_ff <= 2'h0;
        end
        else if (fire)
        begin
            irq_ff[line] <= 1'b1;
            cond_ff[sel] <= 1'b1;
        end
    end

    // Levels held until cleared, so handlers can poll the cause
    assign ext_irq_in              = irq_ff;
    assign branch_condition_inputs = cond_ff;
endmodule

// ===== tb/ems_top_tb.sv
// Self-checking bench for the exception mode stack
`timescale 1ns/10ps
module ems_top_tb
    import ems_pkg::*;
;
    logic        clock, rstn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0]  ext_irq_in;
    logic [1:0]  branch_condition_inputs;
    logic        exc_take, rfe_exec, jump_reg_exec, cop_cond_branch_true;
    logic        cop_cond_branch_false, cond_select, irq_request, kernel_mode;
    logic        global_irq_enable, kernel_user_flag, target_fetch;
    logic        cond_taken, cond_valid, irq, fire, clear, sel;
    logic [2:0]  line;
    int          fails, n_checks;

    ems_top ems_top_i (.clock(clock), .rstn(rstn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_irq_in(ext_irq_in),
        .branch_condition_inputs(branch_condition_inputs), .exc_take(exc_take),
        .rfe_exec(rfe_exec), .jump_reg_exec(jump_reg_exec),
        .cop_cond_branch_true(cop_cond_branch_true),
        .cop_cond_branch_false(cop_cond_branch_false), .cond_select(cond_select),
        .irq_request(irq_request), .kernel_mode(kernel_mode),
        .global_irq_enable(global_irq_enable), .kernel_user_flag(kernel_user_flag),
        .target_fetch(target_fetch), .cond_taken(cond_taken),
        .cond_valid(cond_valid), .irq(irq));

    ems_agent ems_agent_i (.clock(clock), .fire(fire), .clear(clear), .line(line),
        .sel(sel), .ext_irq_in(ext_irq_in),
        .branch_condition_inputs(branch_condition_inputs));

    // 125 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task summarize;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // One APB transfer; waits for pready under a bound
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic e);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        e = pslverr;
        // A hung slave ends the run through the common verdict
        if (n >= 20)
        begin
            chk("pready", 0, 1);
            summarize;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        logic e;
        apb(1'b1, a, d, e);
        chk("wr_err", e, 0);
    endtask

    task waitc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Drives one pipeline pulse; 0 exception, 1 return
    task pulse(input int k);
        @(posedge clock);
        if (k == 0) exc_take <= 1'b1; else rfe_exec <= 1'b1;
        @(posedge clock);
        exc_take <= 1'b0;
        rfe_exec <= 1'b0;
        #1;
    endtask

    task agent_ev(input logic f, input int s);
        @(posedge clock);
        fire <= f;
        clear <= !f;
        line <= s[2:0];
        sel <= s[0];
        @(posedge clock);
        fire <= 1'b0;
        clear <= 1'b0;
        waitc(4);
    endtask

    task t_reset;
        logic e;
        chk("kmode_rst", kernel_mode, 1);
        apb(1'b0, 12'h000, 32'h0000_0000, e);
        chk("mode_rst", rd, 32'h0000_0000);
        apb(1'b0, 12'h010, 32'h0000_0000, e);
        chk("unmapped", e, 1);
        $display("test reset done");
    endtask

    task t_stack;
        logic e;
        wr(12'h000, 32'h0000_001b);
        pulse(0);
        chk("ie_exc", global_irq_enable, 0);
        chk("kmode_exc", kernel_mode, 1);
        apb(1'b0, 12'h000, 32'h0000_0000, e);
        chk("stack_push", rd[5:0], 6'h2c);
        pulse(1);
        chk("ku_pop", kernel_user_flag, 1);
        chk("kmode_user", kernel_mode, 0);
        apb(1'b0, 12'h000, 32'h0000_0000, e);
        chk("stack_pop", rd[5:0], 6'h2b);
        // Return in the jump slot acts before the target fetch
        wr(12'h000, 32'h0000_0004);
        @(posedge clock);
        jump_reg_exec <= 1'b1;
        @(posedge clock);
        jump_reg_exec <= 1'b0;
        rfe_exec <= 1'b1;
        @(posedge clock);
        rfe_exec <= 1'b0;
        #1;
        chk("tgt_fetch", target_fetch, 1);
        chk("ie_slot", global_irq_enable, 1);
        $display("test stack done");
    endtask

    // Each maskable source needs its own mask bit and the enable
    task t_mask;
        for (int i = 0; i < 8; i++)
        begin
            wr(12'h000, 32'h0000_0001 | (32'h0000_0100 << i));
            waitc(4);
            chk("irq_idle", irq_request, 0);
            if (i < 6) agent_ev(1'b1, i); else wr(12'h004, 32'h0000_0001 << (i - 6));
            waitc(4);
            chk("irq_on", irq_request, 1);
            wr(12'h000, 32'h0000_0100 << i);
            waitc(2);
            chk("irq_ie_off", irq_request, 0);
            wr(12'h000, 32'h0000_0001 | (32'h0000_0100 << ((i + 1) % 8)));
            waitc(2);
            chk("irq_other", irq_request, 0);
            agent_ev(1'b0, 0);
            wr(12'h004, 32'h0000_0000);
        end
        $display("test mask done");
    endtask

    // Both branch forms against both inputs at both levels
    task t_branch;
        for (int s = 0; s < 2; s++)
            for (int v = 0; v < 2; v++)
                for (int f = 0; f < 2; f++)
                begin
                    agent_ev(v[0], s);
                    @(posedge clock);
                    cop_cond_branch_true <= f[0];
                    cop_cond_branch_false <= !f[0];
                    cond_select <= s[0];
                    @(posedge clock);
                    cop_cond_branch_true <= 1'b0;
                    cop_cond_branch_false <= 1'b0;
                    #1;
                    chk("cvalid", cond_valid, 1);
                    chk("ctaken", cond_taken, f ? v : !v);
                end
        $display("test branch done");
    endtask

    task t_status;
        logic e;
        wr(12'h008, 32'h0000_000f);
        wr(12'h00c, 32'h0000_0001);
        pulse(0);
        waitc(2);
        chk("irq_set", irq, 1);
        apb(1'b0, 12'h008, 32'h0000_0000, e);
        chk("status", rd[0], 1);
        wr(12'h008, 32'h0000_0001);
        waitc(2);
        chk("irq_clr", irq, 0);
        $display("test status done");
    endtask

    // Watchdog against a hung handshake
    initial
    begin
        #200000;
        fails++;
        summarize;
    end

    initial
    begin
        {rstn, psel, penable, pwrite, exc_take, rfe_exec, jump_reg_exec} = 7'h00;
        {cop_cond_branch_true, cop_cond_branch_false, cond_select, fire, clear} = 5'h00;
        {paddr, pwdata, line, sel, fails, n_checks} = '0;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        waitc(5);
        t_reset;
        t_stack;
        t_mask;
        t_branch;
        t_status;
        summarize;
    end
endmodule
